//--- src/fmd_pkg.sv
// constants shared by the float multiply/divide/compare unit
package fmd_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADR_OP1_LO = 8'h00;
  localparam logic [7:0] ADR_OP1_HI = 8'h04;
  localparam logic [7:0] ADR_OP2_LO = 8'h08;
  localparam logic [7:0] ADR_OP2_HI = 8'h0C;
  localparam logic [7:0] ADR_IMM1 = 8'h10;
  localparam logic [7:0] ADR_IMM2 = 8'h14;
  localparam logic [7:0] ADR_CTRL = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_RES_LO = 8'h20;
  localparam logic [7:0] ADR_RES_HI = 8'h24;

  // control register layout
  localparam int CTRL_W = 10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_REL_LSB = 2;
  localparam int CTRL_CONN_LSB = 5;
  localparam int CTRL_IMM1_BIT = 7;
  localparam int CTRL_IMM2_BIT = 8;
  localparam int CTRL_NEW_RUNG_BIT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // operations
  localparam logic [1:0] OP_CMP = 2'h0;
  localparam logic [1:0] OP_MUL = 2'h1;
  localparam logic [1:0] OP_DIV = 2'h2;

  // relations
  localparam logic [2:0] REL_EQ = 3'h0;
  localparam logic [2:0] REL_NE = 3'h1;
  localparam logic [2:0] REL_LT = 3'h2;
  localparam logic [2:0] REL_LE = 3'h3;
  localparam logic [2:0] REL_GT = 3'h4;
  localparam logic [2:0] REL_GE = 3'h5;

  // connection forms
  localparam logic [1:0] CONN_LD = 2'h0;
  localparam logic [1:0] CONN_AND = 2'h1;
  localparam logic [1:0] CONN_OR = 2'h2;

  // status register layout
  localparam int ST_FAULT = 0;
  localparam int ST_ABOVE = 1;
  localparam int ST_ABOVE_SAME = 2;
  localparam int ST_SAME = 3;
  localparam int ST_DIFFER = 4;
  localparam int ST_BELOW = 5;
  localparam int ST_BELOW_SAME = 6;
  localparam int ST_TOO_LARGE = 7;
  localparam int ST_TOO_SMALL = 8;
  localparam int ST_NEG = 9;
  localparam int FLAGS_W = 10;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 10'h000;

  // single-precision layout
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  localparam logic [9:0] EXP_BIAS = 10'h07F;
  localparam logic [9:0] EXP_LIMIT = 10'h0FF;
  localparam int FRAC_W = 23;

  typedef enum logic [0:0] {FMD_ST_IDLE, FMD_ST_DIV} fmd_state_t;

endpackage

//--- src/fmd_compare.sv
// ordered single-precision comparator with special-value detection
module fmd_compare (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output logic eq_o,
  output logic lt_o,
  output logic gt_o,
  output logic fault_o,
  output logic nan_o
);
  logic a_nan;
  logic b_nan;
  logic a_inf;
  logic b_inf;
  logic both_zero;
  logic mag_lt;
  logic a_lt_raw;

  assign a_nan = (a_i[30:23] == fmd_pkg::EXP_ALL_ONES) && (a_i[22:0] != 23'h00_0000);
  assign b_nan = (b_i[30:23] == fmd_pkg::EXP_ALL_ONES) && (b_i[22:0] != 23'h00_0000);
  assign a_inf = (a_i[30:23] == fmd_pkg::EXP_ALL_ONES) && (a_i[22:0] == 23'h00_0000);
  assign b_inf = (b_i[30:23] == fmd_pkg::EXP_ALL_ONES) && (b_i[22:0] == 23'h00_0000);
  assign nan_o = a_nan | b_nan;
  assign fault_o = a_nan | b_nan | a_inf | b_inf;
  // plus and minus zero compare equal
  assign both_zero = (a_i[30:0] == 31'h0000_0000) && (b_i[30:0] == 31'h0000_0000);
  assign mag_lt = a_i[30:0] < b_i[30:0];
  assign a_lt_raw = (a_i[31] != b_i[31]) ? a_i[31] :
                    (a_i[31] ? (b_i[30:0] < a_i[30:0]) : mag_lt);
  assign eq_o = !nan_o && ((a_i == b_i) || both_zero);
  assign lt_o = !nan_o && !eq_o && a_lt_raw;
  assign gt_o = !nan_o && !eq_o && !a_lt_raw;
endmodule

//--- src/fmd_divider.sv
// restoring divider for normalised mantissas, one quotient bit per cycle
module fmd_divider #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic busy_o,
  output logic done_o,
  output logic [W:0] quotient_o
);
  localparam int CW = $clog2(W + 2);

  generate
    if (W < 2)
    begin : g_bad_width
      $error("fmd_divider: W must be at least 2");
    end
  endgenerate

  logic [W:0] rem;
  logic [W:0] quo;
  logic [CW-1:0] count;
  logic [W:0] diff;
  logic take;

  assign diff = rem - {1'b0, divisor_i};
  assign take = rem >= {1'b0, divisor_i};

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rem <= '0;
      quo <= '0;
      count <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      quotient_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy_o)
      begin
        rem <= {1'b0, dividend_i};
        quo <= '0;
        count <= CW'(W + 1);
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        rem <= {(take ? diff[W-1:0] : rem[W-1:0]), 1'b0};
        quo <= {quo[W-1:0], take};
        count <= count - 1'b1;
        if (count == CW'(1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          quotient_o <= {quo[W-1:0], take};
        end
      end
    end
  end
endmodule

//--- src/fmd_unit.sv
// float multiply/divide/compare unit with classic wishbone register slave
// Function
// RL1 - multiply zero by infinity: fault set, destination left unwritten
// RL2 - finite products underflow to zero, overflow to infinity; infinite operands give infinity
// RL3 - zero over zero, infinity over infinity fault; nonzero over zero gives infinity
// RL4 - finite or zero over infinity gives zero; tiny quotients give zero
// RL5 - compare operands as single-precision; condition true only when relation holds
// RL6 - fault flag set when either compare operand is NaN or infinite
// RL7 - above, above-or-same and same flags follow the relation of first to second
// RL8 - differ, below and below-or-same flags follow the relation of first to second
// RL9 - comparison leaves the negative flag unchanged
// RL10 - each operand comes from two consecutive words or an eight-digit immediate
// RL11 - six relations times load, and, or forms: eighteen variants
// RL12 - load and or may start a rung; and may not
// RL13 - comparison result joins rung condition like a basic contact
// RL14 - result too large: too-large flag set, signed infinity written
// RL15 - result too small: too-small flag set, zero written
// RL16 - result low half to lower word, high half to next word
// RL17 - NaN operand in multiply or divide: fault set, destination unwritten
// RL18 - infinite or zero product or quotient sign is xor of operand signs
//
// Design decisions made here: the address map and the Wishbone register port.
module fmd_unit (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rung_cond_o,
  output logic busy_o
);
  localparam int MW = fmd_pkg::FRAC_W + 1;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [15:0] op1_lo;
  logic [15:0] op1_hi;
  logic [15:0] op2_lo;
  logic [15:0] op2_hi;
  logic [31:0] imm1;
  logic [31:0] imm2;
  logic [fmd_pkg::CTRL_W-1:0] ctrl;
  logic [fmd_pkg::FLAGS_W-1:0] flags;
  logic [15:0] res_lo;
  logic [15:0] res_hi;
  logic rung_cond;
  logic refused;
  logic go;
  fmd_pkg::fmd_state_t state;

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_op1_lo = wb_adr_i == fmd_pkg::ADR_OP1_LO;
  wire hit_op1_hi = wb_adr_i == fmd_pkg::ADR_OP1_HI;
  wire hit_op2_lo = wb_adr_i == fmd_pkg::ADR_OP2_LO;
  wire hit_op2_hi = wb_adr_i == fmd_pkg::ADR_OP2_HI;
  wire hit_imm1 = wb_adr_i == fmd_pkg::ADR_IMM1;
  wire hit_imm2 = wb_adr_i == fmd_pkg::ADR_IMM2;
  wire hit_ctrl = wb_adr_i == fmd_pkg::ADR_CTRL;
  wire hit_status = wb_adr_i == fmd_pkg::ADR_STATUS;
  wire hit_res_lo = wb_adr_i == fmd_pkg::ADR_RES_LO;
  wire hit_res_hi = wb_adr_i == fmd_pkg::ADR_RES_HI;
  wire [31:0] wr_op1_lo = merge({16'h0000, op1_lo}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_op1_hi = merge({16'h0000, op1_hi}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_op2_lo = merge({16'h0000, op2_lo}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_op2_hi = merge({16'h0000, op2_hi}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_ctrl = merge({22'h00_0000, ctrl}, wb_dat_i, wb_sel_i);
  wire [31:0] status_word = {19'h0_0000, refused, busy_o, rung_cond, flags};
  wire [31:0] rd_mux =
    hit_op1_lo ? {16'h0000, op1_lo} :
    hit_op1_hi ? {16'h0000, op1_hi} :
    hit_op2_lo ? {16'h0000, op2_lo} :
    hit_op2_hi ? {16'h0000, op2_hi} :
    hit_imm1 ? imm1 :
    hit_imm2 ? imm2 :
    hit_ctrl ? {22'h00_0000, ctrl} :
    hit_status ? status_word :
    hit_res_lo ? {16'h0000, res_lo} :
    hit_res_hi ? {16'h0000, res_hi} : 32'h0000_0000;
  // a control write while busy is dropped and remembered in status
  wire ctrl_wr = bus_wr && hit_ctrl;
  wire ctrl_take = ctrl_wr && !busy_o;
  // decoded control fields
  wire [1:0] op = ctrl[fmd_pkg::CTRL_OP_LSB +: 2];
  wire [2:0] rel = ctrl[fmd_pkg::CTRL_REL_LSB +: 3];
  wire [1:0] conn = ctrl[fmd_pkg::CTRL_CONN_LSB +: 2];
  wire new_rung = ctrl[fmd_pkg::CTRL_NEW_RUNG_BIT];
  wire is_cmp = op == fmd_pkg::OP_CMP;
  wire is_mul = op == fmd_pkg::OP_MUL;
  wire is_div = op == fmd_pkg::OP_DIV;
  // operands: word pair, low word first, or immediate
  wire [31:0] opa = ctrl[fmd_pkg::CTRL_IMM1_BIT] ? imm1 : {op1_hi, op1_lo}; // RL10
  wire [31:0] opb = ctrl[fmd_pkg::CTRL_IMM2_BIT] ? imm2 : {op2_hi, op2_lo}; // RL10
  // comparison
  logic c_eq;
  logic c_lt;
  logic c_gt;
  logic c_fault;
  logic c_nan;
  fmd_compare u_cmp (
    .a_i(opa),
    .b_i(opb),
    .eq_o(c_eq),
    .lt_o(c_lt),
    .gt_o(c_gt),
    .fault_o(c_fault),
    .nan_o(c_nan)
  );
  wire c_ne = !c_nan && !c_eq;
  wire c_le = c_lt || c_eq;
  wire c_ge = c_gt || c_eq;
  wire rel_ok = (rel == fmd_pkg::REL_EQ) ? c_eq : // RL5 RL11
                (rel == fmd_pkg::REL_NE) ? c_ne :
                (rel == fmd_pkg::REL_LT) ? c_lt :
                (rel == fmd_pkg::REL_LE) ? c_le :
                (rel == fmd_pkg::REL_GT) ? c_gt :
                (rel == fmd_pkg::REL_GE) ? c_ge : 1'b0;
  wire bad_form = (conn != fmd_pkg::CONN_LD) && (conn != fmd_pkg::CONN_AND)
                  && (conn != fmd_pkg::CONN_OR);
  wire bad_rel = rel > fmd_pkg::REL_GE;
  wire and_at_rail = (conn == fmd_pkg::CONN_AND) && new_rung; // RL12
  wire cmp_refuse = bad_form || bad_rel || and_at_rail;
  wire next_rung_cond =
    (conn == fmd_pkg::CONN_AND) ? (rung_cond && rel_ok) : // RL13
    (conn == fmd_pkg::CONN_OR && !new_rung) ? (rung_cond || rel_ok) : rel_ok; // RL12 RL13
  // operand classes for multiply and divide
  wire sign_r = opa[31] ^ opb[31]; // RL18
  wire a_zero = opa[30:23] == 8'h00;
  wire b_zero = opb[30:23] == 8'h00;
  wire a_max = opa[30:23] == fmd_pkg::EXP_ALL_ONES;
  wire b_max = opb[30:23] == fmd_pkg::EXP_ALL_ONES;
  wire a_inf = a_max && (opa[22:0] == 23'h00_0000);
  wire b_inf = b_max && (opb[22:0] == 23'h00_0000);
  wire a_nan = a_max && !a_inf;
  wire b_nan = b_max && !b_inf;
  wire md_err = a_nan || b_nan // RL17
                || (is_mul && ((a_zero && b_inf) || (a_inf && b_zero))) // RL1
                || (is_div && ((a_zero && b_zero) || (a_inf && b_inf))); // RL3
  wire md_inf = is_mul ? (a_inf || b_inf) : (a_inf || (b_zero && !a_zero)); // RL2 RL3
  wire md_zero = is_mul ? (a_zero || b_zero) : (a_zero || b_inf); // RL4
  wire md_special = md_err || md_inf || md_zero;
  // multiply mantissas
  wire [MW-1:0] man_a = {1'b1, opa[22:0]};
  wire [MW-1:0] man_b = {1'b1, opb[22:0]};
  wire [2*MW-1:0] prod = man_a * man_b;
  wire [9:0] mul_exp = {2'b00, opa[30:23]} + {2'b00, opb[30:23]} - fmd_pkg::EXP_BIAS
                       + {9'h000, prod[2*MW-1]};
  wire [22:0] mul_frac = prod[2*MW-1] ? prod[2*MW-2 -: 23] : prod[2*MW-3 -: 23];

  // divide mantissas
  logic dv_start;
  logic dv_busy;
  logic dv_done;
  logic [MW:0] quo;

  fmd_divider #(
    .W(MW)
  ) u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(dv_start),
    .dividend_i(man_a),
    .divisor_i(man_b),
    .busy_o(dv_busy),
    .done_o(dv_done),
    .quotient_o(quo)
  );

  wire [9:0] div_exp = {2'b00, opa[30:23]} - {2'b00, opb[30:23]} + fmd_pkg::EXP_BIAS
                       - 10'h001 + {9'h000, quo[MW]};
  wire [22:0] div_frac = quo[MW] ? quo[MW-1:1] : quo[MW-2:0];

  // truncation and range check, exponent held as signed 10 bits
  wire [9:0] fin_exp = is_mul ? mul_exp : div_exp;
  wire [22:0] fin_frac = is_mul ? mul_frac : div_frac;
  wire fin_ovf = !fin_exp[9] && (fin_exp >= fmd_pkg::EXP_LIMIT);
  wire fin_unf = fin_exp[9] || (fin_exp == 10'h000);
  wire [31:0] inf_word = {sign_r, fmd_pkg::EXP_ALL_ONES, 23'h00_0000};
  wire [31:0] zero_word = {sign_r, 31'h0000_0000};
  wire [31:0] md_word =
    md_inf ? inf_word : // RL2 RL18
    md_zero ? zero_word : // RL4 RL18
    fin_ovf ? inf_word : // RL14
    fin_unf ? zero_word : // RL15
    {sign_r, fin_exp[7:0], fin_frac}; // RL2
  wire md_big = !md_special && fin_ovf;
  wire md_small = !md_special && !fin_ovf && fin_unf;
  wire md_is_zero = md_word[30:0] == 31'h0000_0000;

  // completion events
  wire in_idle = state == fmd_pkg::FMD_ST_IDLE;
  wire cmp_go = go && in_idle && is_cmp;
  wire md_now = go && in_idle && (is_mul || (is_div && md_special));
  wire md_commit = md_now || (state == fmd_pkg::FMD_ST_DIV && dv_done);
  assign dv_start = go && in_idle && is_div && !md_special;
  assign busy_o = go || !in_idle || dv_busy;
  assign rung_cond_o = rung_cond;

  // bus slave: one wait-free ack per request
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

  // operand and control registers
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      op1_lo <= 16'h0000;
      op1_hi <= 16'h0000;
      op2_lo <= 16'h0000;
      op2_hi <= 16'h0000;
      imm1 <= 32'h0000_0000;
      imm2 <= 32'h0000_0000;
      ctrl <= fmd_pkg::CTRL_RESET;
    end
    else if (bus_wr && !busy_o)
    begin
      if (hit_op1_lo) op1_lo <= wr_op1_lo[15:0];
      if (hit_op1_hi) op1_hi <= wr_op1_hi[15:0];
      if (hit_op2_lo) op2_lo <= wr_op2_lo[15:0];
      if (hit_op2_hi) op2_hi <= wr_op2_hi[15:0];
      if (hit_imm1) imm1 <= merge(imm1, wb_dat_i, wb_sel_i);
      if (hit_imm2) imm2 <= merge(imm2, wb_dat_i, wb_sel_i);
      if (hit_ctrl) ctrl <= wr_ctrl[fmd_pkg::CTRL_W-1:0];
    end
  end

  // sequencing
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      go <= 1'b0;
      state <= fmd_pkg::FMD_ST_IDLE;
    end
    else
    begin
      go <= ctrl_take;
      case (state)
        fmd_pkg::FMD_ST_IDLE:
        begin
          if (dv_start)
          begin
            state <= fmd_pkg::FMD_ST_DIV;
          end
        end
        fmd_pkg::FMD_ST_DIV:
        begin
          if (dv_done)
          begin
            state <= fmd_pkg::FMD_ST_IDLE;
          end
        end
        default:
        begin
          state <= fmd_pkg::FMD_ST_IDLE;
        end
      endcase
    end
  end

  // flags, rung condition and result words
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      flags <= fmd_pkg::FLAGS_RESET;
      rung_cond <= 1'b0;
      refused <= 1'b0;
      res_lo <= 16'h0000;
      res_hi <= 16'h0000;
    end
    else
    begin
      if (ctrl_wr)
      begin
        refused <= busy_o;
      end
      if (cmp_go && cmp_refuse)
      begin
        refused <= 1'b1; // RL12
      end
      else if (cmp_go)
      begin
        flags[fmd_pkg::ST_FAULT] <= c_fault; // RL6
        flags[fmd_pkg::ST_ABOVE] <= c_gt; // RL7
        flags[fmd_pkg::ST_ABOVE_SAME] <= c_ge; // RL7
        flags[fmd_pkg::ST_SAME] <= c_eq; // RL7
        flags[fmd_pkg::ST_DIFFER] <= c_ne; // RL8
        flags[fmd_pkg::ST_BELOW] <= c_lt; // RL8
        flags[fmd_pkg::ST_BELOW_SAME] <= c_le; // RL8 RL9
        rung_cond <= next_rung_cond; // RL13
      end
      else if (md_commit && md_err)
      begin
        flags[fmd_pkg::ST_FAULT] <= 1'b1; // RL1 RL3 RL17
      end
      else if (md_commit)
      begin
        flags[fmd_pkg::ST_FAULT] <= 1'b0;
        flags[fmd_pkg::ST_SAME] <= md_is_zero;
        flags[fmd_pkg::ST_TOO_LARGE] <= md_big; // RL14
        flags[fmd_pkg::ST_TOO_SMALL] <= md_small; // RL15
        flags[fmd_pkg::ST_NEG] <= md_word[31] && !md_is_zero;
        res_lo <= md_word[15:0]; // RL16
        res_hi <= md_word[31:16]; // RL16
      end
    end
  end
endmodule

//--- test/fmd_unit_checker.sv
// port-level assertions for the float multiply/divide/compare unit
module fmd_unit_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rung_cond_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic go = take & wb_we_i & (wb_adr_i == fmd_pkg::ADR_CTRL) & ~busy_o
    & (wb_sel_i == 4'hF);
  wire logic [1:0] op = wb_dat_i[1:0];
  wire logic ld = (wb_dat_i[6:5] == fmd_pkg::CONN_LD) & (wb_dat_i[4:2] < 3'h6);
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("request not acked in next cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_cmp_one_cycle: assert property (go & ld & (op == fmd_pkg::OP_CMP)
    |=> busy_o ##1 !busy_o)
    else $error("compare not done in one cycle");
  a_mul_one_cycle: assert property (go & (op == fmd_pkg::OP_MUL) |=> busy_o ##1 !busy_o)
    else $error("multiply not done in one cycle");
  a_div_bounded: assert property (go & (op == fmd_pkg::OP_DIV) |=> busy_o ##[1:30] !busy_o)
    else $error("divide did not finish in time");
  a_rung_by_op: assert property ($changed(rung_cond_o) |-> $past(busy_o))
    else $error("rung condition moved without an operation");
  a_busy_from_ctrl: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy rose without control write");
  c_cmp_or: cover property (go & (wb_dat_i[6:5] == fmd_pkg::CONN_OR));
  c_div_run: cover property (go & (op == fmd_pkg::OP_DIV));
  c_rung_up: cover property ($rose(rung_cond_o));
endmodule

bind fmd_unit fmd_unit_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rung_cond_o(rung_cond_o), .busy_o(busy_o));

//--- test/test_fmd_unit.sv
// self-checking bench for the float multiply/divide/compare unit
module test_fmd_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] M = fmd_pkg::OP_MUL;
  localparam logic [1:0] D = fmd_pkg::OP_DIV;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic rung_cond_o;
  logic busy_o;
  logic [31:0] st;
  logic [31:0] r;
  int errors = 0;
  int total_checks = 0;
  // compare table: first, second, {relation flags, fault}
  logic [31:0] ca [7] = '{32'h3F80_0000, 32'hBF80_0000, 32'h0000_0000, 32'hC000_0000,
    32'h7F80_0000, 32'h3F80_0000, 32'h7FC0_0000};
  logic [31:0] cb [7] = '{32'h4000_0000, 32'h3F80_0000, 32'h8000_0000, 32'hC040_0000,
    32'h3F80_0000, 32'hFF80_0000, 32'h3F80_0000};
  logic [6:0] cf [7] = '{7'h70, 7'h70, 7'h4C, 7'h16, 7'h17, 7'h17, 7'h01};
  int rb [6] = '{3, 4, 5, 6, 1, 2};
  // mul/div table: op, operands, result, {too_small, too_large, fault}
  logic [1:0] mo [14] = '{M, M, M, M, M, M, M, D, D, D, D, D, D, D};
  logic [31:0] ma [14] = '{32'h4000_0000, 32'h0000_0000, 32'h7FC0_0000, 32'h7F80_0000,
    32'h7F00_0000, 32'h0080_0000, 32'h0000_0000, 32'h0000_0000, 32'h7F80_0000,
    32'hBF80_0000, 32'h3F80_0000, 32'h40C0_0000, 32'h0080_0000, 32'h3F80_0000};
  logic [31:0] mb [14] = '{32'h4040_0000, 32'h7F80_0000, 32'h3F80_0000, 32'hC000_0000,
    32'h7F00_0000, 32'h0080_0000, 32'hBF80_0000, 32'h0000_0000, 32'hFF80_0000,
    32'h0000_0000, 32'h7F80_0000, 32'h4000_0000, 32'h7F00_0000, 32'h8000_0000};
  logic [31:0] mr [14] = '{32'h40C0_0000, 32'h40C0_0000, 32'h40C0_0000, 32'hFF80_0000,
    32'h7F80_0000, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 32'h8000_0000,
    32'hFF80_0000, 32'h0000_0000, 32'h4040_0000, 32'h0000_0000, 32'hFF80_0000};
  logic [2:0] mf [14] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h2, 3'h4, 3'h0, 3'h1, 3'h1, 3'h0,
    3'h0, 3'h0, 3'h4, 3'h0};

  always #50 clk_i = ~clk_i;

  fmd_unit DUT (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rung_cond_o(rung_cond_o), .busy_o(busy_o));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one classic cycle; held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0000_0000, q);
  endtask

  function automatic logic [9:0] cc(input logic [1:0] op, input logic [2:0] rel,
    input logic [1:0] fm, input logic nr);
    return {nr, 2'b00, fm, rel, op};
  endfunction

  task automatic run(input logic [9:0] c, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] lo;
    logic [31:0] hi;
    int n;
    n = 0;
    wr(fmd_pkg::ADR_OP1_LO, {16'h0000, a[15:0]});
    wr(fmd_pkg::ADR_OP1_HI, {16'h0000, a[31:16]});
    wr(fmd_pkg::ADR_OP2_LO, {16'h0000, b[15:0]});
    wr(fmd_pkg::ADR_OP2_HI, {16'h0000, b[31:16]});
    wr(fmd_pkg::ADR_CTRL, {22'h0, c});
    while (busy_o !== 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, busy_o}, 32'h0000_0000);
    rd(fmd_pkg::ADR_STATUS, st);
    rd(fmd_pkg::ADR_RES_LO, lo);
    rd(fmd_pkg::ADR_RES_HI, hi);
    r = {hi[15:0], lo[15:0]};
  endtask

  task automatic s_reset();
    logic [31:0] q;
    rd(fmd_pkg::ADR_STATUS, q);
    check(q, 32'h0000_0000);
    wr(fmd_pkg::ADR_STATUS, 32'hFFFF_FFFF);
    rd(fmd_pkg::ADR_STATUS, q);
    check(q, 32'h0000_0000);
    rd(8'h30, q);
    check(q, 32'h0000_0000);
    check({30'h0, rung_cond_o, busy_o}, 32'h0000_0000);
  endtask

  task automatic s_compare();
    logic [1:0] f;
    logic res;
    logic prev;
    prev = 1'b0;
    for (int i = 0; i < 7; i++)
      for (int k = 0; k < 6; k++)
      begin
        f = 2'((i + k) % 3);
        res = cf[i][rb[k]];
        run(cc(fmd_pkg::OP_CMP, 3'(k), f, 1'b0), ca[i], cb[i]);
        prev = (f == fmd_pkg::CONN_LD) ? res : (f == fmd_pkg::CONN_AND) ? prev & res : prev | res;
        check({25'h0, st[6:0]}, {25'h0, cf[i]});
        check({31'h0, rung_cond_o}, {31'h0, prev});
      end
  endtask

  task automatic fcase(input logic [9:0] c, input logic ec, input logic er);
    run(c, 32'h3F80_0000, 32'h4000_0000);
    check({31'h0, rung_cond_o}, {31'h0, ec});
    check({31'h0, st[12]}, {31'h0, er});
  endtask

  task automatic s_forms();
    run(cc(M, 3'h0, 2'h0, 1'b0), 32'hBF80_0000, 32'h4000_0000);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_LT, fmd_pkg::CONN_LD, 1'b1), 1'b1, 1'b0);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_GT, fmd_pkg::CONN_AND, 1'b1), 1'b1, 1'b1);
    fcase(cc(fmd_pkg::OP_CMP, 3'h6, fmd_pkg::CONN_LD, 1'b0), 1'b1, 1'b1);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_LT, 2'h3, 1'b0), 1'b1, 1'b1);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_GT, fmd_pkg::CONN_OR, 1'b1), 1'b0, 1'b0);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_LT, fmd_pkg::CONN_AND, 1'b1), 1'b0, 1'b1);
    wr(fmd_pkg::ADR_IMM1, 32'h4000_0000);
    wr(fmd_pkg::ADR_IMM2, 32'h3F80_0000);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_GT, 2'h0, 1'b0) | 10'h180, 1'b1, 1'b0);
    fcase(cc(fmd_pkg::OP_CMP, fmd_pkg::REL_EQ, 2'h0, 1'b0) | 10'h080, 1'b1, 1'b0);
    check({31'h0, st[9]}, 32'h0000_0001);
  endtask

  task automatic s_muldiv();
    for (int i = 0; i < 14; i++)
    begin
      run(cc(mo[i], 3'h0, 2'h0, 1'b0), ma[i], mb[i]);
      check(r, mr[i]);
      check({29'h0, st[8:7], st[0]}, {29'h0, mf[i]});
    end
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    s_reset();
    s_compare();
    s_forms();
    s_muldiv();
    complete_run();
  end

  // watchdog well beyond the expected 1600 or so cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule
